// ### shared/sys_mode_pkg.sv
package sys_mode_pkg;

   // Clock and timing figures.
   localparam int CLK_PERIOD_NS     = 4;
   localparam int CNT_W             = 16;
   localparam int T_STARTUP_NS      = 2000;
   localparam int T_MODE_CHANGE_NS  = 200;
   localparam int T_SNM_NS          = 1000;
   localparam int T_MCU_TMO_NS      = 20000;
   localparam int T_WAKE_SHORT_NS   = 200;
   localparam int T_WAKE_LONG_NS    = 800;
   localparam logic [CNT_W-1:0] STARTUP_CYC     = CNT_W'(T_STARTUP_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] MODE_CHANGE_CYC = CNT_W'(T_MODE_CHANGE_NS / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] SNM_CYC         = CNT_W'((T_SNM_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] MCU_TMO_CYC_DEF = CNT_W'((T_MCU_TMO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WAKE_SHORT_CYC  = CNT_W'((T_WAKE_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [CNT_W-1:0] WAKE_LONG_CYC   = CNT_W'((T_WAKE_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

   // Register port.
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam logic [ADDR_W-1:0] ADDR_MODE_CTRL  = 8'h00;
   localparam logic [ADDR_W-1:0] ADDR_SYS_STATUS = 8'h04;
   localparam logic [ADDR_W-1:0] ADDR_WAKE_CFG   = 8'h08;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'h0C;
   localparam logic [ADDR_W-1:0] ADDR_SYS_RESET  = 8'h10;
   localparam logic [DATA_W-1:0] SYS_RESET_KEY   = 8'hA5;

   // Mode codes.
   localparam logic [3:0] MC_NORMAL  = 4'hF;
   localparam logic [3:0] MC_STANDBY = 4'h6;
   localparam logic [3:0] MC_LISTEN  = 4'h8;
   localparam logic [3:0] MC_SLEEP   = 4'h1;

   // Field positions and reset values.
   localparam int STAT_DSF   = 0;
   localparam int STAT_WPL   = 1;
   localparam int STAT_TMO   = 2;
   localparam int STAT_OT    = 3;
   localparam int STAT_MODE  = 4;
   localparam int WCFG_RISE  = 0;
   localparam int WCFG_FALL  = 1;
   localparam int WCFG_FILT  = 2;
   localparam int IRQ_RISE   = 0;
   localparam int IRQ_FALL   = 1;
   localparam int IRQ_PWRON  = 2;
   localparam int IRQ_WAKE   = 3;
   localparam logic [2:0] WAKE_CFG_RST  = 3'h3;
   localparam logic [3:0] MODE_CODE_RST = MC_STANDBY;

   // System modes, Gray coded along Off, Boot, check, Normal, listen, Standby, Sleep.
   typedef enum logic [2:0] {
      MODE_OFF     = 3'h0,
      MODE_BOOT    = 3'h1,
      MODE_CHECK   = 3'h3,
      MODE_NORMAL  = 3'h2,
      MODE_LISTEN  = 3'h6,
      MODE_STANDBY = 3'h7,
      MODE_SLEEP   = 3'h5
   } sys_mode_t;

endpackage

// ### rtl/wake_pin_filter.sv
`timescale 1ns/1ns
module wake_pin_filter
   import sys_mode_pkg::*;
(
   input  wire logic clk_i,
   input  wire logic rst_b_i,
   input  wire logic clk_en_i,
   input  wire logic enable_i,
   input  wire logic pin_i,
   input  wire logic long_sel_i,
   output logic      level_o,
   output logic      rise_o,
   output logic      fall_o
);

   typedef struct packed {
      logic             sync1;
      logic             sync2;
      logic             stable;
      logic [CNT_W-1:0] cnt;
      logic             rise;
      logic             fall;
   } filt_state_t;

   filt_state_t r;
   filt_state_t n;
   logic [CNT_W-1:0] limit;

   // Synchronise, then accept a new level only once it has held for the filter time.
   always_comb begin
      n       = r;
      n.sync1 = pin_i;
      n.sync2 = r.sync1;
      n.rise  = 1'b0;
      n.fall  = 1'b0;
      limit   = long_sel_i ? WAKE_LONG_CYC : WAKE_SHORT_CYC;
      if (r.sync2 == r.stable) begin
         n.cnt = '0;
      end else if (r.cnt + 1'b1 >= limit) begin
         n.stable = r.sync2;
         n.cnt    = '0;
         n.rise   = enable_i & r.sync2;
         n.fall   = enable_i & ~r.sync2;
      end else begin
         n.cnt = r.cnt + 1'b1;
      end
   end

   // State register.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '0;
      end else if (clk_en_i) begin
         r <= n;
      end
   end

   assign level_o = r.stable;
   assign rise_o  = r.rise;
   assign fall_o  = r.fall;

   // A change of the filtered level follows a held differing input.
   filter_hold_a: assert property (@(posedge clk_i) disable iff (!rst_b_i)
      clk_en_i && (r.stable != n.stable) |-> r.sync2 != r.stable && r.cnt + 1'b1 >= limit)
      else $error("Wake level changed before the filter time.");

endmodule

// ### rtl/system_mode_machine.sv
`timescale 1ns/1ns
module system_mode_machine
   import sys_mode_pkg::*;
#(
   parameter logic [CNT_W-1:0] MCU_TMO_CYC = MCU_TMO_CYC_DEF
)(
   input  wire logic              clk_i,
   input  wire logic              rst_b_i,
   input  wire logic              clk_en_i,
   input  wire logic              bat_uv_i,
   input  wire logic              mem_check_done_i,
   input  wire logic              mem_check_pass_i,
   input  wire logic              bus_dominant_i,
   input  wire logic              overtemp_i,
   input  wire logic              remote_wake_i,
   input  wire logic              wake_pin_i,
   input  wire logic              chip_select_n_i,
   input  wire logic              serial_data_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] wdata_i,
   input  wire logic              wr_i,
   input  wire logic              rd_i,
   output logic      [DATA_W-1:0] rdata_o,
   output logic      [2:0]        mode_o,
   output logic                   inhibit_output_o,
   output logic                   inhibit_output_oe_o,
   output logic                   rxd_o,
   output logic                   rxd_oe_o,
   output logic                   serial_out_pin_o,
   output logic                   serial_out_pin_oe_o,
   output logic                   overtemp_det_en_o,
   output logic                   host_reaction_timeout_o
);

   typedef struct packed {
      sys_mode_t        mode;
      logic [CNT_W-1:0] cnt;
      logic [CNT_W-1:0] tmo_cnt;
      logic [3:0]       mode_code_field;
      logic [2:0]       wake_cfg;
      logic [3:0]       irq;
      logic             direct_start_flag;
      logic             tmo;
      logic             ot_keep;
      logic             spi_seen;
      logic             boot_fail;
      logic [DATA_W-1:0] rdata;
   } mode_state_t;

   mode_state_t r;
   mode_state_t n;

   logic wake_level;
   logic wake_rise;
   logic wake_fall;
   logic active;
   logic access;
   logic reset_cmd;
   logic mode_wr;
   logic irq_pending;
   logic local_wake;
   logic [3:0] irq_set;
   logic [3:0] irq_clr;
   logic [DATA_W-1:0] status_word;

   //////////////////////////////////////////////////////////////////////////////////////////
   // Wake pin filtering; edge events are masked while the device is off, booting or in the start check.
   wake_pin_filter u_wake_filter (
      .clk_i      (clk_i),
      .rst_b_i    (rst_b_i),
      .clk_en_i   (clk_en_i),
      .enable_i   (active),
      .pin_i      (wake_pin_i),
      .long_sel_i (r.wake_cfg[WCFG_FILT]),
      .level_o    (wake_level),
      .rise_o     (wake_rise),
      .fall_o     (wake_fall)
   );

   //////////////////////////////////////////////////////////////////////////////////////////
   // Decoded bus requests and events.
   assign active      = (r.mode == MODE_STANDBY) || (r.mode == MODE_SLEEP) ||
                        (r.mode == MODE_LISTEN) || (r.mode == MODE_NORMAL);
   assign access      = wr_i | rd_i;
   assign reset_cmd   = active && wr_i && (addr_i == ADDR_SYS_RESET) && (wdata_i == SYS_RESET_KEY);
   assign mode_wr     = active && wr_i && (addr_i == ADDR_MODE_CTRL);
   assign irq_pending = |r.irq;
   assign local_wake  = (wake_rise & r.wake_cfg[WCFG_RISE]) | (wake_fall & r.wake_cfg[WCFG_FALL]);
   assign irq_clr     = (active && wr_i && (addr_i == ADDR_IRQ_STATUS)) ? wdata_i[3:0] : 4'h0;

   // Status word as seen by software.
   always_comb begin
      status_word            = '0;
      status_word[STAT_DSF]  = r.direct_start_flag;
      status_word[STAT_WPL]  = wake_level;
      status_word[STAT_TMO]  = r.tmo;
      status_word[STAT_OT]   = overtemp_det_en_o;
      status_word[STAT_MODE +: 3] = r.mode;
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // Next-state logic of the whole block.
   always_comb begin
      n       = r;
      irq_set = 4'h0;
      n.rdata = '0;
      if (access) begin
         n.spi_seen = 1'b1;
      end
      // Read data stand for the one cycle after the strobe; unmapped reads give zero.
      if (rd_i && active) begin
         case (addr_i)
            ADDR_MODE_CTRL:  n.rdata = {4'h0, r.mode_code_field};
            ADDR_SYS_STATUS: n.rdata = status_word;
            ADDR_WAKE_CFG:   n.rdata = {5'h00, r.wake_cfg};
            ADDR_IRQ_STATUS: n.rdata = {4'h0, r.irq};
            default:         n.rdata = '0;
         endcase
      end
      if (active && wr_i && (addr_i == ADDR_WAKE_CFG)) begin
         n.wake_cfg = wdata_i[2:0];
      end
      if (mode_wr) begin
         n.mode_code_field = wdata_i[3:0];
      end
      if (wake_rise && r.wake_cfg[WCFG_RISE]) begin
         irq_set[IRQ_RISE] = 1'b1;
      end
      if (wake_fall && r.wake_cfg[WCFG_FALL]) begin
         irq_set[IRQ_FALL] = 1'b1;
      end
      // Host reaction timer runs while a power-on or wake interrupt waits unserviced.
      if (access || !(r.irq[IRQ_PWRON] | r.irq[IRQ_WAKE])) begin
         n.tmo_cnt = '0;
         n.tmo     = access ? 1'b0 : r.tmo;
      end else if (r.tmo_cnt >= MCU_TMO_CYC) begin
         n.tmo = 1'b1;
      end else begin
         n.tmo_cnt = r.tmo_cnt + 1'b1;
      end
      // Mode machine: undervoltage first, reset command second, the rest exclusive.
      if (bat_uv_i) begin
         n.mode      = MODE_OFF;
         n.boot_fail = 1'b0;
         n.cnt       = '0;
      end else if (reset_cmd) begin
         n.mode = MODE_BOOT;
         n.cnt  = '0;
      end else begin
         case (r.mode)
            MODE_OFF: begin
               if (!r.boot_fail) begin
                  n.mode = MODE_BOOT;
               end
            end
            MODE_BOOT: begin
               // Defaults are reloaded on every boot cycle.
               n.mode_code_field   = MODE_CODE_RST;
               n.wake_cfg          = WAKE_CFG_RST;
               n.direct_start_flag = 1'b0;
               n.tmo               = 1'b0;
               n.ot_keep           = 1'b0;
               n.spi_seen          = 1'b0;
               n.tmo_cnt           = '0;
               n.cnt               = r.cnt + 1'b1;
               if (mem_check_done_i && mem_check_pass_i) begin
                  irq_set[IRQ_PWRON] = 1'b1;
                  n.cnt              = '0;
                  n.mode = bus_dominant_i ? MODE_CHECK : MODE_STANDBY;
               end else if ((mem_check_done_i && !mem_check_pass_i) || (r.cnt >= STARTUP_CYC)) begin
                  n.mode      = MODE_OFF;
                  n.boot_fail = 1'b1;
                  n.cnt       = '0;
               end
            end
            MODE_CHECK: begin
               if (!bus_dominant_i || r.spi_seen || access) begin
                  n.mode = MODE_STANDBY;
                  n.cnt  = '0;
               end else if (r.cnt >= SNM_CYC) begin
                  n.mode              = MODE_NORMAL;
                  n.direct_start_flag = 1'b1;
                  n.cnt               = '0;
               end else begin
                  n.cnt = r.cnt + 1'b1;
               end
            end
            MODE_SLEEP: begin
               if (local_wake || remote_wake_i) begin
                  n.mode            = MODE_STANDBY;
                  irq_set[IRQ_WAKE] = 1'b1;
               end else if (mode_wr && (wdata_i[3:0] == MC_NORMAL)) begin
                  n.mode = MODE_NORMAL;
               end else if (mode_wr && (wdata_i[3:0] == MC_LISTEN)) begin
                  n.mode = MODE_LISTEN;
               end else if (mode_wr && (wdata_i[3:0] == MC_STANDBY)) begin
                  n.mode = MODE_STANDBY;
               end
            end
            MODE_NORMAL: begin
               if (overtemp_i) begin
                  n.mode    = MODE_LISTEN;
                  n.ot_keep = 1'b1;
               end else if (mode_wr && (wdata_i[3:0] == MC_SLEEP)) begin
                  n.mode = MODE_SLEEP;
               end else if (mode_wr && (wdata_i[3:0] == MC_LISTEN)) begin
                  n.mode = MODE_LISTEN;
               end else if (mode_wr && (wdata_i[3:0] == MC_STANDBY)) begin
                  n.mode = MODE_STANDBY;
               end
            end
            MODE_LISTEN, MODE_STANDBY: begin
               if (local_wake || remote_wake_i) begin
                  irq_set[IRQ_WAKE] = 1'b1;
               end
               if (mode_wr && (wdata_i[3:0] == MC_SLEEP)) begin
                  n.mode = MODE_SLEEP;
               end else if (mode_wr && (wdata_i[3:0] == MC_NORMAL)) begin
                  n.mode = MODE_NORMAL;
               end else if (mode_wr && (wdata_i[3:0] == MC_LISTEN)) begin
                  n.mode = MODE_LISTEN;
               end else if (mode_wr && (wdata_i[3:0] == MC_STANDBY)) begin
                  n.mode = MODE_STANDBY;
               end
            end
            default: begin
               n.mode = MODE_OFF;
            end
         endcase
      end
      // Overtemperature hold only lasts while listen-only lasts.
      if (n.mode != MODE_LISTEN) begin
         n.ot_keep = 1'b0;
      end
      // Setting wins over a clear in the same cycle; Boot keeps only the flags set in that cycle.
      n.irq = (r.mode == MODE_BOOT) ? irq_set : ((r.irq & ~irq_clr) | irq_set);
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // State register; a mode change lands on the next edge.
   always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         r <= '0;
      end else if (clk_en_i) begin
         r <= n;
      end
   end

   //////////////////////////////////////////////////////////////////////////////////////////
   // Pin behaviour per mode.
   assign mode_o                  = r.mode;
   assign rdata_o                 = r.rdata;
   assign inhibit_output_o        = active && (r.mode != MODE_SLEEP);
   assign inhibit_output_oe_o     = active && (r.mode != MODE_SLEEP);
   assign rxd_oe_o                = active;
   assign rxd_o                   = ((r.mode == MODE_SLEEP) || (r.mode == MODE_STANDBY)) ?
                                    ~irq_pending : ~bus_dominant_i;
   assign serial_out_pin_o        = serial_data_i;
   assign serial_out_pin_oe_o     = active && !chip_select_n_i;
   assign overtemp_det_en_o       = (r.mode == MODE_NORMAL) || ((r.mode == MODE_LISTEN) && r.ot_keep);
   assign host_reaction_timeout_o = r.tmo;

   //////////////////////////////////////////////////////////////////////////////////////////
   // Checks.
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   uv_forces_off_a: assert property (clk_en_i && bat_uv_i |=> r.mode == MODE_OFF)
      else $error("Undervoltage did not force Off.");
   reset_cmd_boot_a: assert property (clk_en_i && !bat_uv_i && reset_cmd |=> r.mode == MODE_BOOT)
      else $error("Reset command did not enter Boot.");
   boot_defaults_a: assert property (clk_en_i && r.mode == MODE_BOOT && !bat_uv_i |=>
      r.wake_cfg == WAKE_CFG_RST && !r.direct_start_flag && !r.spi_seen)
      else $error("Boot did not restore defaults.");
   boot_bound_a: assert property (r.mode == MODE_BOOT |-> r.cnt <= STARTUP_CYC)
      else $error("Boot overran the startup time.");
   snm_flag_a: assert property ($past(r.mode) == MODE_CHECK && r.mode == MODE_NORMAL |->
      r.direct_start_flag && $past(r.cnt) >= SNM_CYC)
      else $error("Direct start without flag or too early.");
   snm_fail_a: assert property (clk_en_i && r.mode == MODE_CHECK && !bus_dominant_i && !bat_uv_i
      |=> r.mode == MODE_STANDBY)
      else $error("Recessive bus did not end the start check.");
   sleep_cmd_a: assert property (r.mode != MODE_SLEEP ##1 r.mode == MODE_SLEEP |->
      $past(mode_wr) && $past(wdata_i[3:0]) == MC_SLEEP)
      else $error("Sleep entered without a sleep write.");
   inh_mode_a: assert property ((r.mode == MODE_STANDBY |-> inhibit_output_o && inhibit_output_oe_o) and
      (r.mode == MODE_SLEEP |-> !inhibit_output_oe_o))
      else $error("Inhibit output wrong for low-power mode.");
   rxd_irq_a: assert property (r.mode == MODE_STANDBY && $past(irq_set) != 4'h0 && $past(clk_en_i) |->
      !rxd_o)
      else $error("Pending interrupt not shown on the receive pin.");
   sdo_idle_a: assert property (chip_select_n_i |-> !serial_out_pin_oe_o)
      else $error("Serial output driven with chip select high.");
   tmo_raise_a: assert property (clk_en_i && !access && (r.irq[IRQ_PWRON] | r.irq[IRQ_WAKE]) &&
      r.tmo_cnt == MCU_TMO_CYC |=> r.tmo)
      else $error("Reaction timeout not raised.");

   cover_direct_start_c: cover property (r.mode == MODE_CHECK ##1 r.mode == MODE_NORMAL);
   cover_sleep_wake_c:   cover property (r.mode == MODE_SLEEP ##1 r.mode == MODE_STANDBY);
   cover_overtemp_c:     cover property (r.mode == MODE_NORMAL ##1 r.mode == MODE_LISTEN && r.ot_keep);

endmodule

// ### dv/host_model.sv
`timescale 1ns/1ns
module host_model
   import sys_mode_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic [DATA_W-1:0] rdata_i,
   output logic      [ADDR_W-1:0] addr_o,
   output logic      [DATA_W-1:0] wdata_o,
   output logic                   wr_o,
   output logic                   rd_o
);
   // Idle port at time zero.
   initial begin
      addr_o = 8'h00;
      wdata_o = 8'h00;
      wr_o = 1'b0;
      rd_o = 1'b0;
   end
   // One write cycle; released lines show the inverse so stale values never pass.
   task automatic write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wdata_o <= ~d;
   endtask
   // One read cycle; data are taken in the cycle after the strobe.
   task automatic read(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk_i);
      addr_o <= a;
      rd_o <= 1'b1;
      @(posedge clk_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      #1;
      d = rdata_i;
   endtask
endmodule

// ### dv/tb_top.sv
`timescale 1ns/1ns
module tb_top;
   import sys_mode_pkg::*;
   typedef struct packed {logic [3:0] code; logic [2:0] mode; logic [1:0] inhibit_output;} row_t;
   localparam row_t ROWS [4] = '{'{MC_LISTEN, MODE_LISTEN, 2'h3}, '{MC_SLEEP, MODE_SLEEP, 2'h0},
                                 '{MC_STANDBY, MODE_STANDBY, 2'h3}, '{MC_NORMAL, MODE_NORMAL, 2'h3}};
   logic              clk_i = 1'b0;
   logic              rst_b_i = 1'b0;
   logic              bat_uv = 1'b0;
   logic              bus_dom = 1'b1;
   logic              wake = 1'b0;
   logic              cs_n = 1'b1;
   logic              ot = 1'b0;
   logic              ot_en;
   logic              sdata = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata, rdata, rv;
   logic              wr, rd, inhibit_output, inh_oe, rxd, rxd_oe, so, so_oe, tmo;
   logic [2:0]        mode;
   int                miscompares = 0;
   int                comparisons = 0;
   int                n;
   // Free-running clock at 250 MHz.
   always #2 clk_i = ~clk_i;
   system_mode_machine #(.MCU_TMO_CYC(16'h0014)) dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .clk_en_i(1'b1),
      .bat_uv_i(bat_uv), .mem_check_done_i(1'b1), .mem_check_pass_i(1'b1), .bus_dominant_i(bus_dom),
      .overtemp_i(ot), .remote_wake_i(1'b0), .wake_pin_i(wake), .chip_select_n_i(cs_n),
      .serial_data_i(sdata), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
      .mode_o(mode), .inhibit_output_o(inhibit_output), .inhibit_output_oe_o(inh_oe), .rxd_o(rxd), .rxd_oe_o(rxd_oe),
      .serial_out_pin_o(so), .serial_out_pin_oe_o(so_oe), .overtemp_det_en_o(ot_en),
      .host_reaction_timeout_o(tmo));
   host_model host (.clk_i(clk_i), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
   // Compares one value and reports a mismatch at once.
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Prints the verdict and ends the run.
   task automatic summarize();
      if (miscompares == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Waits a bounded number of cycles for a mode; n holds the cycles spent.
   task automatic wait_mode(input logic [2:0] m, input int lim);
      n = 0;
      while (mode !== m && n < lim) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk("mode_o", m, mode);
      if (mode !== m) summarize();
   endtask
   // Main sequence: power-on boot, mode table, then the awkward cases.
   initial begin
      repeat (2) @(posedge clk_i);
      #1;
      chk("reset_state", 8'h00, {mode, inh_oe, rxd_oe, so_oe, tmo});
      @(posedge clk_i);
      rst_b_i <= 1'b1;
      wait_mode(MODE_CHECK, STARTUP_CYC);
      wait_mode(MODE_NORMAL, 300);
      chk("check_len", 8'h01, n > SNM_CYC && n <= SNM_CYC + MODE_CHANGE_CYC);
      host.read(ADDR_SYS_STATUS, rv);
      chk("direct_start", 8'h01, rv[STAT_DSF]);
      for (int i = 0; i < 4; i++) begin
         host.write(ADDR_MODE_CTRL, {4'h0, ROWS[i].code});
         @(posedge clk_i);
         #1;
         chk("mode_o", ROWS[i].mode, mode);
         chk("inhibit", ROWS[i].inhibit_output, {inh_oe, inhibit_output});
         chk("so_oe", 8'h00, so_oe);
      end
      cs_n <= 1'b0;
      sdata <= 1'b1;
      @(posedge clk_i);
      #1;
      chk("so_pin", 8'h03, {so_oe, so});
      chk("rxd_bus", 8'h02, {rxd_oe, rxd});
      // Overtemperature in Normal drops to listen-only with detection kept on.
      ot <= 1'b1;
      @(posedge clk_i);
      #1;
      chk("overtemp", 8'h0D, {mode, ot_en});
      ot <= 1'b0;
      host.write(ADDR_SYS_RESET, SYS_RESET_KEY);
      bus_dom <= 1'b0;
      cs_n <= 1'b1;
      #1;
      chk("mode_o", MODE_BOOT, mode);
      wait_mode(MODE_STANDBY, 10);
      chk("rxd_irq", 8'h02, {rxd_oe, rxd});
      wait_mode(MODE_STANDBY, 0);
      while (tmo !== 1'b1 && n < 40) begin
         @(posedge clk_i);
         #1;
         n++;
      end
      chk("timeout", 8'h03, {n > 10, tmo});
      host.read(ADDR_SYS_STATUS, rv);
      chk("direct_start", 8'h00, rv[STAT_DSF]);
      host.write(ADDR_IRQ_STATUS, 8'h0F);
      @(posedge clk_i);
      #1;
      chk("rxd_tmo", 8'h06, {rxd_oe, rxd, tmo});
      host.write(ADDR_WAKE_CFG, 8'h07);
      wake <= 1'b1;
      repeat (WAKE_LONG_CYC + 8) @(posedge clk_i);
      wake <= 1'b0;
      repeat (WAKE_SHORT_CYC + 8) @(posedge clk_i);
      wake <= 1'b1;
      repeat (WAKE_LONG_CYC + 8) @(posedge clk_i);
      host.read(ADDR_IRQ_STATUS, rv);
      chk("wake_irqs", 8'h01, rv[1:0]);
      host.write(ADDR_WAKE_CFG, 8'h03);
      wake <= 1'b0;
      repeat (WAKE_SHORT_CYC + 8) @(posedge clk_i);
      host.read(ADDR_IRQ_STATUS, rv);
      chk("fall_irq", 8'h01, rv[IRQ_FALL]);
      host.read(ADDR_SYS_STATUS, rv);
      chk("wake_level", 8'h00, rv[STAT_WPL]);
      bat_uv <= 1'b1;
      wait_mode(MODE_OFF, 3);
      chk("inhibit", 8'h00, {inh_oe, rxd_oe});
      summarize();
   end
endmodule
